// file: common/vic_pkg.sv
// Constants and types of the vectored interrupt controller
package vic_pkg;
    // ****************
    // Sizes and timing
    // ****************
    localparam int NUM_SLOTS = 16;
    localparam int PERIPH_CYCLE_CLKS = 6;
    localparam logic [2:0] PERIPH_CNT_LAST = 3'(PERIPH_CYCLE_CLKS - 1);

    // ****************
    // Register indices
    // ****************
    localparam logic [7:0] IDX_TIMER_EXT_CTRL = 8'h88;
    localparam logic [7:0] IDX_INT_EN_FIRST = 8'ha8;
    localparam logic [7:0] IDX_INT_EN_SECOND = 8'hb1;
    localparam logic [7:0] IDX_PRIO_LOW_SECOND = 8'hb2;
    localparam logic [7:0] IDX_PRIO_HIGH_SECOND = 8'hb3;
    localparam logic [7:0] IDX_PRIO_HIGH_FIRST = 8'hb7;
    localparam logic [7:0] IDX_PRIO_LOW_FIRST = 8'hb8;

    // ****************
    // Reset values and masks
    // ****************
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] PRIO_RESET = 8'h00;
    localparam logic [7:0] SECOND_MASK = 8'h5f;
    localparam logic [7:0] FIRST_PRIO_MASK = 8'h7f;

    // ****************
    // Field positions
    // ****************
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_T1_OVF = 7;
    localparam int BIT_T1_RUN = 6;
    localparam int BIT_T0_OVF = 5;
    localparam int BIT_T0_RUN = 4;
    localparam int BIT_EXT1_REQ = 3;
    localparam int BIT_EXT1_TYPE = 2;
    localparam int BIT_EXT0_REQ = 1;
    localparam int BIT_EXT0_TYPE = 0;

    // ****************
    // Polling slots and vectors
    // ****************
    localparam logic [3:0] SLOT_EXT0 = 4'h0;
    localparam logic [3:0] SLOT_T0 = 4'h1;
    localparam logic [3:0] SLOT_EXT1 = 4'h2;
    localparam logic [3:0] SLOT_T1 = 4'h3;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic TRIG_EDGE = 1'b1;

    typedef logic [3:0] vic_slot_t;
    typedef logic [1:0] vic_level_t;
    typedef enum logic [0:0] {
        VIC_BUS_IDLE = 1'b0,
        VIC_BUS_ACK = 1'b1
    } vic_bus_state_t;
endpackage

// file: common/vic_arb_if.sv
// Slot requests and winner between the controller and its arbiter
`timescale 1ns/10ps
interface vic_arb_if;
    import vic_pkg::*;
    logic [NUM_SLOTS-1:0] slotReq;
    logic [NUM_SLOTS-1:0][1:0] slotLevel;
    logic winValid;
    vic_slot_t winSlot;
    vic_level_t winLevel;
    modport client (output slotReq, slotLevel, input winValid, winSlot, winLevel);
    modport arbiter (input slotReq, slotLevel, output winValid, winSlot, winLevel);
endinterface

// file: hdl/vic_arbiter.sv
// Level and polling order arbiter of the interrupt controller
`timescale 1ns/10ps
module vic_arbiter
    import vic_pkg::*;
(
    // Slot requests and winner
    vic_arb_if.arbiter arb
);
    // Ascending scan with strict compare keeps the earliest slot on a tie
    always_comb begin
        arb.winValid = 1'b0;
        arb.winSlot = 4'h0;
        arb.winLevel = 2'h0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (arb.slotReq[i]
                && (!arb.winValid || arb.slotLevel[i] > arb.winLevel)) begin
                arb.winValid = 1'b1;
                arb.winSlot = vic_slot_t'(i);
                arb.winLevel = arb.slotLevel[i];
            end
        end
    end
endmodule

// file: hdl/vic_top.sv
// Vectored interrupt controller with Avalon-MM register access
`timescale 1ns/10ps

// Functional notes
// - Global enable at bit 7 of first enable register gates every source.
// - First enable register bits 6..0: audio, decoder, serial, timer1, ext1, timer0, ext0.
// - High and low priority bits form level 0 (lowest) to 3 (highest).
// - Higher level preempts a running routine; equal or lower waits.
// - Equal levels resolve by fixed polling order.
// - Polling: ext0, timer0, ext1, timer1, serial ... keypad, reserved, USB, reserved.
// - Vector is 0003h plus eight times polling position minus one.
// - Timer flags and edge external flags clear on vectoring; others by software.
// - Requests latch into flags before arbitration; winner raises core request.
// - Core finishes instruction, saves PC, loads offered vector.
// - Return from interrupt clears in-progress mark of current level.
// - External pins trigger on low level (type 0) or falling edge (type 1).
// - External events set request flag; edge mode flag clears on vectoring.
// - External and keypad pins sampled once per six-clock peripheral cycle.
// - Low level on either external pin wakes from power-down.
// - Second enable register: USB 6, keypad 4, converter 3, SPI 2, two-wire 1, MMC 0.
// - Priority registers mirror enable layouts of their pair.
module vic_top
    import vic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // External pins, active low
    input wire logic extPinZeroN,
    input wire logic extPinOneN,
    input wire logic [3:0] keypadInputs,
    // Peripheral request lines
    input wire logic timer0Overflow,
    input wire logic timer1Overflow,
    input wire logic serialIrq,
    input wire logic decoderIrq,
    input wire logic audioIrq,
    input wire logic mmcIrq,
    input wire logic twoWireIrq,
    input wire logic spiIrq,
    input wire logic converterIrq,
    input wire logic keypadIrq,
    input wire logic usbIrq,
    // Core execution unit
    output logic irqRequest,
    output logic [15:0] irqVector,
    input wire logic irqAccept,
    input wire logic retiExec,
    // Power and peripheral side
    input wire logic powerDown,
    output logic wakeRequest,
    output logic [3:0] keypadSampled,
    output logic [1:0] timerRun
);
    // ************************
    // State
    // ************************
    typedef struct packed {
        vic_bus_state_t busState;
        logic [31:0] readData;
        logic [7:0] ctrl;
        logic [7:0] enFirst;
        logic [7:0] enSecond;
        logic [7:0] prioHighFirst;
        logic [7:0] prioLowFirst;
        logic [7:0] prioHighSecond;
        logic [7:0] prioLowSecond;
        logic [2:0] perCnt;
        logic [1:0] pinSample;
        logic [3:0] keypadSample;
        logic [8:0] periphLatch;
        logic [3:0] inProgress;
        logic irqReq;
        vic_slot_t reqSlot;
        vic_level_t reqLevel;
        logic [15:0] vector;
        logic wake;
    } vic_state_t;

    vic_state_t stateReg;
    vic_state_t stateNext;

    vic_arb_if arb ();

    vic_arbiter u_arbiter (
        .arb(arb.arbiter)
    );

    // ************************
    // Slot mapping
    // ************************
    logic [NUM_SLOTS-1:0] slotFlag;
    logic [NUM_SLOTS-1:0] slotEnable;
    logic [NUM_SLOTS-1:0] slotPrioHigh;
    logic [NUM_SLOTS-1:0] slotPrioLow;
    logic globalEn;

    assign globalEn = stateReg.enFirst[BIT_GLOBAL_EN];

    // Reserved slots 12, 14 and 15 are tied low
    assign slotFlag = {2'b00, stateReg.periphLatch[8], 1'b0, stateReg.periphLatch[7:0],
        stateReg.ctrl[BIT_T1_OVF], stateReg.ctrl[BIT_EXT1_REQ],
        stateReg.ctrl[BIT_T0_OVF], stateReg.ctrl[BIT_EXT0_REQ]};
    assign slotEnable = {2'b00, stateReg.enSecond[6], 1'b0,
        stateReg.enSecond[4:0], stateReg.enFirst[6:0]};
    assign slotPrioHigh = {2'b00, stateReg.prioHighSecond[6], 1'b0,
        stateReg.prioHighSecond[4:0], stateReg.prioHighFirst[6:0]};
    assign slotPrioLow = {2'b00, stateReg.prioLowSecond[6], 1'b0,
        stateReg.prioLowSecond[4:0], stateReg.prioLowFirst[6:0]};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
            assign arb.slotReq[gi] = globalEn & slotEnable[gi] & slotFlag[gi];
            assign arb.slotLevel[gi] = {slotPrioHigh[gi], slotPrioLow[gi]};
        end
    endgenerate

    // ************************
    // Level in service
    // ************************
    logic inProgAny;
    vic_level_t curLevel;

    always_comb begin
        inProgAny = |stateReg.inProgress;
        if (stateReg.inProgress[3]) begin
            curLevel = 2'h3;
        end else if (stateReg.inProgress[2]) begin
            curLevel = 2'h2;
        end else if (stateReg.inProgress[1]) begin
            curLevel = 2'h1;
        end else begin
            curLevel = 2'h0;
        end
    end

    // ************************
    // Bus decode
    // ************************
    logic busReq;
    logic wrCommit;
    logic [7:0] regIdx;
    logic aligned;
    logic [7:0] wrByte;
    logic [7:0] rdByte;

    assign busReq = avs_read | avs_write;
    assign regIdx = avs_address[9:2];
    assign aligned = (avs_address[1:0] == 2'b00);
    assign wrByte = avs_writedata[7:0];
    assign wrCommit = avs_write & avs_byteenable[0] & aligned
        & (stateReg.busState == VIC_BUS_ACK);
    assign avs_waitrequest = busReq & (stateReg.busState == VIC_BUS_IDLE);

    // Unmapped or misaligned words read as zero
    always_comb begin
        rdByte = 8'h00;
        if (aligned) begin
            unique case (regIdx)
                IDX_TIMER_EXT_CTRL: rdByte = stateReg.ctrl;
                IDX_INT_EN_FIRST: rdByte = stateReg.enFirst;
                IDX_INT_EN_SECOND: rdByte = stateReg.enSecond;
                IDX_PRIO_LOW_SECOND: rdByte = stateReg.prioLowSecond;
                IDX_PRIO_HIGH_SECOND: rdByte = stateReg.prioHighSecond;
                IDX_PRIO_HIGH_FIRST: rdByte = stateReg.prioHighFirst;
                IDX_PRIO_LOW_FIRST: rdByte = stateReg.prioLowFirst;
                default: rdByte = 8'h00;
            endcase
        end
    end

    // ************************
    // Pin sampling and events
    // ************************
    logic tick;
    logic [1:0] pinNow;
    logic [1:0] trigType;
    logic [1:0] extEvent;

    assign tick = (stateReg.perCnt == PERIPH_CNT_LAST);
    assign pinNow = {extPinOneN, extPinZeroN};
    assign trigType = {stateReg.ctrl[BIT_EXT1_TYPE], stateReg.ctrl[BIT_EXT0_TYPE]};

    always_comb begin
        for (int n = 0; n < 2; n++) begin
            if (trigType[n] == TRIG_EDGE) begin
                extEvent[n] = tick & stateReg.pinSample[n] & ~pinNow[n];
            end else begin
                extEvent[n] = tick & ~pinNow[n];
            end
        end
    end

    // ************************
    // Vectoring
    // ************************
    logic accept;
    logic raise;
    logic [7:0] hwClear;
    logic [7:0] hwSet;
    logic [7:0] ctrlBase;
    logic [3:0] progAfterRet;

    assign accept = irqAccept & stateReg.irqReq;
    assign raise = arb.winValid & (!inProgAny || arb.winLevel > curLevel);

    always_comb begin
        hwClear = 8'h00;
        if (accept) begin
            unique case (stateReg.reqSlot)
                SLOT_T0: hwClear[BIT_T0_OVF] = 1'b1;
                SLOT_T1: hwClear[BIT_T1_OVF] = 1'b1;
                SLOT_EXT0: hwClear[BIT_EXT0_REQ] = trigType[0];
                SLOT_EXT1: hwClear[BIT_EXT1_REQ] = trigType[1];
                default: hwClear = 8'h00;
            endcase
        end
    end

    always_comb begin
        hwSet = 8'h00;
        hwSet[BIT_T0_OVF] = timer0Overflow;
        hwSet[BIT_T1_OVF] = timer1Overflow;
        hwSet[BIT_EXT0_REQ] = extEvent[0];
        hwSet[BIT_EXT1_REQ] = extEvent[1];
    end

    always_comb begin
        ctrlBase = stateReg.ctrl;
        if (wrCommit && regIdx == IDX_TIMER_EXT_CTRL) begin
            ctrlBase = wrByte;
        end
    end

    // Return drops only the highest level mark
    always_comb begin
        progAfterRet = stateReg.inProgress;
        if (retiExec && inProgAny) begin
            progAfterRet[curLevel] = 1'b0;
        end
    end

    // ************************
    // Next state
    // ************************
    always_comb begin
        stateNext = stateReg;

        // Bus handshake, one wait cycle per access
        unique case (stateReg.busState)
            VIC_BUS_IDLE: begin
                if (busReq) begin
                    stateNext.busState = VIC_BUS_ACK;
                    stateNext.readData = {24'h000000, avs_read ? rdByte : 8'h00};
                end
            end
            VIC_BUS_ACK: begin
                stateNext.busState = VIC_BUS_IDLE;
            end
        endcase

        // Software writes
        if (wrCommit) begin
            unique case (regIdx)
                IDX_INT_EN_FIRST: stateNext.enFirst = wrByte;
                IDX_INT_EN_SECOND: stateNext.enSecond = wrByte & SECOND_MASK;
                IDX_PRIO_LOW_SECOND: stateNext.prioLowSecond = wrByte & SECOND_MASK;
                IDX_PRIO_HIGH_SECOND: stateNext.prioHighSecond = wrByte & SECOND_MASK;
                IDX_PRIO_HIGH_FIRST: stateNext.prioHighFirst = wrByte & FIRST_PRIO_MASK;
                IDX_PRIO_LOW_FIRST: stateNext.prioLowFirst = wrByte & FIRST_PRIO_MASK;
                default: stateNext.enFirst = stateReg.enFirst;
            endcase
        end

        // Hardware set wins over any clear in the same cycle
        stateNext.ctrl = (ctrlBase & ~hwClear) | hwSet;

        // Peripheral cycle sampling
        stateNext.perCnt = tick ? 3'h0 : stateReg.perCnt + 3'h1;
        if (tick) begin
            stateNext.pinSample = pinNow;
            stateNext.keypadSample = keypadInputs;
        end

        // Peripheral flags are held in their own blocks and cleared there
        stateNext.periphLatch = {usbIrq, keypadIrq, converterIrq, spiIrq, twoWireIrq,
            mmcIrq, audioIrq, decoderIrq, serialIrq};

        // In-progress marks
        stateNext.inProgress = progAfterRet;
        if (accept) begin
            stateNext.inProgress[stateReg.reqLevel] = 1'b1;
        end

        // Request and vector travel together
        stateNext.irqReq = raise & ~accept;
        if (!stateReg.irqReq || !accept) begin
            stateNext.reqSlot = arb.winSlot;
            stateNext.reqLevel = arb.winLevel;
            stateNext.vector = VEC_BASE + {9'h000, arb.winSlot, 3'b000};
        end

        stateNext.wake = powerDown & (~extPinZeroN | ~extPinOneN);
    end

    // ************************
    // Registers
    // ************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg.busState <= VIC_BUS_IDLE;
            stateReg.readData <= 32'h00000000;
            stateReg.ctrl <= CTRL_RESET;
            stateReg.enFirst <= ENABLE_RESET;
            stateReg.enSecond <= ENABLE_RESET;
            stateReg.prioHighFirst <= PRIO_RESET;
            stateReg.prioLowFirst <= PRIO_RESET;
            stateReg.prioHighSecond <= PRIO_RESET;
            stateReg.prioLowSecond <= PRIO_RESET;
            stateReg.perCnt <= 3'h0;
            stateReg.pinSample <= 2'b11;
            stateReg.keypadSample <= 4'hf;
            stateReg.periphLatch <= 9'h000;
            stateReg.inProgress <= 4'h0;
            stateReg.irqReq <= 1'b0;
            stateReg.reqSlot <= 4'h0;
            stateReg.reqLevel <= 2'h0;
            stateReg.vector <= VEC_BASE;
            stateReg.wake <= 1'b0;
        end else begin
            stateReg <= stateNext;
        end
    end

    // ************************
    // Outputs
    // ************************
    assign avs_readdata = stateReg.readData;
    assign irqRequest = stateReg.irqReq;
    assign irqVector = stateReg.vector;
    assign wakeRequest = stateReg.wake;
    assign keypadSampled = stateReg.keypadSample;
    assign timerRun = {stateReg.ctrl[BIT_T1_RUN], stateReg.ctrl[BIT_T0_RUN]};
endmodule

// file: test/vic_core_model.sv
// Behavioural model of the core execution unit that takes interrupts
`timescale 1ns/10ps
module vic_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request from the controller
    input wire logic irqRequest,
    input wire logic [15:0] irqVector,
    // Bench control: serve requests, wait cycles before accepting
    input wire logic go,
    input wire logic [1:0] lat,
    // Acceptance and record
    output logic irqAccept,
    output logic [15:0] lastVec,
    output logic [15:0] nAcc
);
    logic [1:0] cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 2'h0;
            irqAccept <= 1'b0;
            lastVec <= 16'h0;
            nAcc <= 16'h0;
        end else begin
            irqAccept <= 1'b0;
            // Vector becomes the new program counter at the accepting edge
            if (irqAccept && irqRequest) begin
                lastVec <= irqVector;
                nAcc <= nAcc + 16'h1;
            end
            if (go && irqRequest && !irqAccept) begin
                cnt <= cnt + 2'h1;
                if (cnt == lat) begin
                    irqAccept <= 1'b1;
                    cnt <= 2'h0;
                end
            end else begin
                cnt <= 2'h0;
            end
        end
    end
endmodule

// file: test/vic_top_checker.sv
// Port assertions of the vectored interrupt controller
`timescale 1ns/10ps
module vic_top_checker
    import vic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins and core link
    input wire logic extPinZeroN,
    input wire logic extPinOneN,
    input wire logic [3:0] keypadSampled,
    input wire logic irqRequest,
    input wire logic [15:0] irqVector,
    input wire logic irqAccept,
    input wire logic powerDown,
    input wire logic wakeRequest
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_hold5;
        $stable(keypadSampled) [*5];
    endsequence
    a_bus_one_wait: assert property (s_req |=> !avs_waitrequest)
        else $error("bus wait too long");
    a_bus_idle_low: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait without request");
    a_read_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_accept_drop: assert property (irqAccept && irqRequest |=> !irqRequest)
        else $error("request stays after accept");
    a_vector_slot: assert property (irqRequest
        |-> irqVector[2:0] == 3'h3 && irqVector[15:7] == 9'h0)
        else $error("vector off slot grid");
    a_reserved_silent: assert property (irqRequest
        |-> irqVector != 16'h0063 && irqVector != 16'h0073)
        else $error("reserved slot vectored");
    a_wake_follow: assert property ($past(rst_n)
        |-> wakeRequest == $past(powerDown && !(extPinZeroN && extPinOneN)))
        else $error("wake mismatch");
    a_keypad_hold: assert property ($changed(keypadSampled) |=> s_hold5)
        else $error("keypad sampled too often");
endmodule

// file: test/tb_vic_top.sv
// Self-checking testbench of the vectored interrupt controller
`timescale 1ns/10ps
module tb_vic_top;
    import vic_pkg::*;
    // ****************
    // Signals and instances
    // ****************
    logic clk, rst_n, read, write, waitReq, go, p0n, p1n, pd, return_from_interrupt_instr, wake, irqRequest, irqAccept;
    logic [9:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] kin, kOut;
    logic [1:0] tp, lat, run;
    logic [8:0] per;
    logic [15:0] vec, lastVec, nAcc;
    logic [7:0] ri [6] = '{IDX_INT_EN_FIRST, IDX_INT_EN_SECOND, IDX_PRIO_LOW_SECOND,
        IDX_PRIO_HIGH_SECOND, IDX_PRIO_HIGH_FIRST, IDX_PRIO_LOW_FIRST};
    logic [7:0] rm [6] = '{8'hff, 8'h5f, 8'h5f, 8'h5f, 8'h7f, 8'h7f};
    int bk [4] = '{0, 3, 7, 8};
    logic [15:0] vk [4] = '{16'h0023, 16'h003b, 16'h005b, 16'h006b};
    int miscompares = 0;
    int nTests = 0;
    vic_top vic_top_inst (.clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(read),
        .avs_write(write), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
        .avs_waitrequest(waitReq), .extPinZeroN(p0n), .extPinOneN(p1n), .keypadInputs(kin),
        .timer0Overflow(tp[0]), .timer1Overflow(tp[1]), .serialIrq(per[0]), .decoderIrq(per[1]),
        .audioIrq(per[2]), .mmcIrq(per[3]), .twoWireIrq(per[4]), .spiIrq(per[5]),
        .converterIrq(per[6]), .keypadIrq(per[7]), .usbIrq(per[8]), .irqRequest(irqRequest),
        .irqVector(vec), .irqAccept(irqAccept), .retiExec(return_from_interrupt_instr), .powerDown(pd),
        .wakeRequest(wake), .keypadSampled(kOut), .timerRun(run));
    vic_core_model vic_core_model_inst (.clk(clk), .rst_n(rst_n), .irqRequest(irqRequest),
        .irqVector(vec), .go(go), .lat(lat), .irqAccept(irqAccept), .lastVec(lastVec),
        .nAcc(nAcc));
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        write <= 1'b1;
        do @(posedge clk); while (waitReq !== 1'b0);
        write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        @(posedge clk);
        addr <= {idx, 2'b00};
        read <= 1'b1;
        do @(posedge clk); while (waitReq !== 1'b0);
        d = rdata[7:0];
        read <= 1'b0;
    endtask
    task automatic pulse_return_from_interrupt_instr();
        @(posedge clk);
        return_from_interrupt_instr <= 1'b1;
        @(posedge clk);
        return_from_interrupt_instr <= 1'b0;
    endtask
    task automatic quiet(input string nm);
        logic s;
        s = 1'b0;
        repeat (8) begin
            @(posedge clk);
            s = s | irqRequest;
        end
        chk(nm, 32'h0, {31'h0, s});
    endtask
    task automatic serve(input logic [15:0] v);
        logic [15:0] n;
        n = nAcc;
        @(posedge clk);
        go <= 1'b1;
        repeat (60) if (nAcc == n) @(posedge clk);
        go <= 1'b0;
        chk("accept and vector", {n + 16'h1, v}, {nAcc, lastVec});
    endtask
    task automatic print_verdict();
        $display("counts: %0d compares, %0d mismatches", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic test_regs();
        logic [7:0] d;
        rd(IDX_TIMER_EXT_CTRL, d);
        chk("ctrl reset", {24'h0, CTRL_RESET}, {24'h0, d});
        for (int i = 0; i < 6; i++) begin
            rd(ri[i], d);
            chk("reg reset", 32'h0, {24'h0, d});
            wr(ri[i], 8'hff);
            rd(ri[i], d);
            chk("reg mask", {24'h0, rm[i]}, {24'h0, d});
            wr(ri[i], 8'h00);
        end
        wr(8'h00, 8'hff);
        rd(8'h00, d);
        chk("unmapped", 32'h0, {24'h0, d});
        $display("test regs done");
    endtask
    task automatic test_timer();
        logic [7:0] d;
        wr(IDX_INT_EN_FIRST, 8'h0a);
        @(posedge clk);
        tp <= 2'b11;
        @(posedge clk);
        tp <= 2'b00;
        quiet("global off");
        rd(IDX_TIMER_EXT_CTRL, d);
        chk("timer flags", 32'ha0, {24'h0, d});
        wr(IDX_INT_EN_FIRST, 8'h8a);
        serve(16'h000b);
        pulse_return_from_interrupt_instr();
        serve(16'h001b);
        rd(IDX_TIMER_EXT_CTRL, d);
        chk("timer flags cleared", 32'h0, {24'h0, d});
        wr(IDX_TIMER_EXT_CTRL, 8'h50);
        @(posedge clk);
        chk("timer run", 32'h3, {30'h0, run});
        wr(IDX_TIMER_EXT_CTRL, 8'h00);
        @(posedge clk);
        chk("timer stop", 32'h0, {30'h0, run});
        pulse_return_from_interrupt_instr();
        $display("test timer done");
    endtask
    task automatic test_poll();
        wr(IDX_INT_EN_FIRST, 8'hf0);
        wr(IDX_INT_EN_SECOND, 8'h5f);
        per <= 9'h1ff;
        for (int i = 0; i < 9; i++) begin
            serve((i < 8) ? 16'h0023 + 16'(8 * i) : 16'h006b);
            per[i] <= 1'b0;
            pulse_return_from_interrupt_instr();
        end
        $display("test poll done");
    endtask
    task automatic test_prio();
        lat <= 2'h3;
        wr(IDX_PRIO_LOW_SECOND, 8'h41);
        wr(IDX_PRIO_HIGH_SECOND, 8'h50);
        for (int k = 0; k < 4; k++) begin
            per <= 9'h001 << bk[k];
            serve(vk[k]);
        end
        per <= 9'h001;
        quiet("lower waits");
        repeat (3) pulse_return_from_interrupt_instr();
        quiet("equal waits");
        pulse_return_from_interrupt_instr();
        serve(16'h0023);
        per[0] <= 1'b0;
        pulse_return_from_interrupt_instr();
        $display("test prio done");
    endtask
    task automatic test_ext();
        logic [7:0] d;
        wr(IDX_INT_EN_SECOND, 8'h00);
        wr(IDX_INT_EN_FIRST, 8'h85);
        wr(IDX_TIMER_EXT_CTRL, 8'h01);
        p0n <= 1'b0;
        kin <= 4'h5;
        pd <= 1'b1;
        repeat (12) @(posedge clk);
        chk("wake", 32'h1, {31'h0, wake});
        chk("keypad", 32'h5, {28'h0, kOut});
        p0n <= 1'b1;
        pd <= 1'b0;
        serve(16'h0003);
        rd(IDX_TIMER_EXT_CTRL, d);
        chk("edge flag", 32'h01, {24'h0, d});
        pulse_return_from_interrupt_instr();
        wr(IDX_TIMER_EXT_CTRL, 8'h00);
        p1n <= 1'b0;
        repeat (12) @(posedge clk);
        p1n <= 1'b1;
        serve(16'h0013);
        rd(IDX_TIMER_EXT_CTRL, d);
        chk("level flag", 32'h08, {24'h0, d});
        wr(IDX_TIMER_EXT_CTRL, 8'h00);
        pulse_return_from_interrupt_instr();
        quiet("level cleared");
        $display("test ext done");
    endtask
    // ****************
    // Run control
    // ****************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
    initial begin
        {rst_n, read, write, go, pd, return_from_interrupt_instr, tp, lat, per} = '0;
        {p0n, p1n, kin, addr, wdata} = {2'b11, 4'hf, 10'h0, 32'h0};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_timer();
        test_poll();
        test_prio();
        test_ext();
        print_verdict();
    end
endmodule

bind vic_top vic_top_checker vic_top_checker_inst (.clk(clk), .rst_n(rst_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .extPinZeroN(extPinZeroN), .extPinOneN(extPinOneN),
    .keypadSampled(keypadSampled), .irqRequest(irqRequest), .irqVector(irqVector),
    .irqAccept(irqAccept), .powerDown(powerDown), .wakeRequest(wakeRequest));
